// [design/usb_irq_pkg.sv]
// Purpose: Shared constants and carriers for the USB interrupt and endpoint status block.
// Assumes: 10 MHz system clock, AXI4-Lite register access, 8-bit registers in the low byte.
// Notes:   Byte offsets are word aligned; reserved bits read as zero.
package usb_irq_pkg;

  // Register byte offsets.
  localparam logic [11:0] OFF_PTR_LOW   = 12'h000;
  localparam logic [11:0] OFF_PTR_HIGH  = 12'h004;
  localparam logic [11:0] OFF_CTRL_A    = 12'h008;
  localparam logic [11:0] OFF_CTRL_B    = 12'h00C;
  localparam logic [11:0] OFF_FLAGA_CLR = 12'h010;
  localparam logic [11:0] OFF_FLAGA_SET = 12'h014;
  localparam logic [11:0] OFF_FLAGB_CLR = 12'h018;
  localparam logic [11:0] OFF_FLAGB_SET = 12'h01C;
  localparam logic [11:0] OFF_TRIM_LOW  = 12'h020;
  localparam logic [11:0] OFF_TRIM_HIGH = 12'h024;
  localparam logic [11:0] OFF_LINK_STAT = 12'h028;
  localparam logic [11:0] OFF_EP_BASE   = 12'h100;
  localparam logic [11:0] OFF_EP_LAST   = 12'h17C;

  // Control register A and B field positions.
  localparam int BIT_SOF_EN   = 7;
  localparam int BIT_BUSEV_EN = 6;
  localparam int BIT_FAULT_EN = 5;
  localparam int BIT_STALL_EN = 4;
  localparam int BIT_XFER_EN  = 1;
  localparam int BIT_SETUP_EN = 0;

  // Flag register A and B positions.
  localparam int FA_SOF   = 7;
  localparam int FA_IDLE  = 6;
  localparam int FA_WAKE  = 5;
  localparam int FA_RESET = 4;
  localparam int FA_CRC   = 3;
  localparam int FA_STARV = 2;
  localparam int FA_REFUS = 1;
  localparam int FA_STALL = 0;
  localparam int FB_XFER  = 1;
  localparam int FB_SETUP = 0;

  // Endpoint status bit positions.
  localparam int EP_STALL_CRC = 7;
  localparam int EP_STARVE    = 6;
  localparam int EP_XFER_DONE = 5;
  localparam int EP_XFER_ALT  = 4;

  // Descriptor layout.
  localparam int EP_COUNT     = 16;
  localparam int EP_STRIDE    = 16;
  localparam int EP_IN_OFFSET = 8;

  // Reset values and writable masks.
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] MASK_CTRL_A  = 8'hF3;
  localparam logic [7:0] MASK_CTRL_B  = 8'h03;
  localparam logic [7:0] MASK_PTR_LOW = 8'hFE;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Suspend detection timing.
  localparam int IDLE_TIME_US = 3000;
  localparam int CLK_MHZ      = 10;
  localparam int IDLE_CYCLES  = IDLE_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    LINK_ACTIVE    = 2'b01,
    LINK_SUSPENDED = 2'b10
  } link_state_type;

  // One endpoint event reported by the transfer engine.
  typedef struct packed {
    logic       valid;
    logic [3:0] ep_num;
    logic       dir_in;
    logic       iso;
    logic       stall;
    logic       crc_err;
    logic       starved;
    logic       xfer_ok;
    logic       setup_ok;
  } ep_event_type;

endpackage

// [design/usb_irq_status.sv]
// Purpose: Interrupt enables, interrupt flags and endpoint status for a USB device.
// Assumes: Transfer engine reports bus and endpoint events as one-cycle pulses.
// Notes:   Registers are reached over AXI4-Lite with one write and one read in flight.
// Functional notes
// - High byte of descriptor table pointer register.
// - Control A bit 7 enables frame-start interrupt.
// - Bit 6 enables idle, wake, reset interrupts.
// - Bit 5 enables check error, starve, refuse.
// - Bit 4 enables stall interrupt.
// - Zero level field suppresses every interrupt.
// - Control B bit 1 enables transfer-done interrupt.
// - Control B bit 0 enables setup-done interrupt.
// - Clear and set addresses, ones act, same read.
// - Frame-start packet sets flag bit 7.
// - Three milliseconds idle sets flag bit 6.
// - Bus activity while suspended sets wake asynchronously.
// - Bus reset condition sets flag bit 4.
// - Isochronous check failure sets flag bit 3.
// - Starved IN endpoint sets flag bit 2.
// - Refused OUT data sets flag bit 1.
// - Stall handshake sets flag bit 0.
// - Pending completion sets B1; setup sets B0.
// - Sixteen endpoints, OUT at base+16n, IN +8.
// - Status bit 7 stall or OUT isochronous error.
// - Status bit 6 starve or refuse.
// - Bits 5 and 4 mark completions, write-one clears.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module usb_irq_status
#(
  parameter int IDLE_LIMIT = usb_irq_pkg::IDLE_CYCLES
)
(
  // Clock and reset
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_in,
  // AXI4-Lite slave
  input  wire logic                       s_axi_awvalid_in,
  output      logic                       s_axi_awready_out,
  input  wire logic [11:0]                s_axi_awaddr_in,
  input  wire logic                       s_axi_wvalid_in,
  output      logic                       s_axi_wready_out,
  input  wire logic [31:0]                s_axi_wdata_in,
  input  wire logic [3:0]                 s_axi_wstrb_in,
  output      logic                       s_axi_bvalid_out,
  input  wire logic                       s_axi_bready_in,
  output      logic [1:0]                 s_axi_bresp_out,
  input  wire logic                       s_axi_arvalid_in,
  output      logic                       s_axi_arready_out,
  input  wire logic [11:0]                s_axi_araddr_in,
  output      logic                       s_axi_rvalid_out,
  input  wire logic                       s_axi_rready_in,
  output      logic [31:0]                s_axi_rdata_out,
  output      logic [1:0]                 s_axi_rresp_out,
  // Bus events from the line front end
  input  wire logic                       sof_rx_in,
  input  wire logic                       bus_idle_in,
  input  wire logic                       bus_reset_in,
  input  wire logic                       fifo_pending_in,
  input  wire usb_irq_pkg::ep_event_type  ep_event_in,
  // Descriptor address of the last endpoint event
  output      logic [15:0]                desc_addr_out,
  output      logic                       desc_valid_out,
  // Pad trim value and interrupt outputs
  output      logic [15:0]                pad_trim_out,
  output      logic                       irq_out,
  output      logic [1:0]                 irq_level_out,
  output      logic                       bus_wake_out
);

  typedef struct packed {
    logic                        aw_held;
    logic                        w_held;
    logic [11:0]                 awaddr;
    logic [7:0]                  wdata;
    logic                        wstrb0;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [7:0]                  rdata;
    logic [1:0]                  rresp;
    logic [7:0]                  ptr_low;
    logic [7:0]                  ptr_high;
    logic [7:0]                  ctrl_a;
    logic [7:0]                  ctrl_b;
    logic [7:0]                  flags_a;
    logic [7:0]                  flags_b;
    logic [7:0]                  trim_low;
    logic [7:0]                  trim_high;
    usb_irq_pkg::link_state_type link;
    logic [15:0]                 idle_cnt;
    logic [15:0]                 desc_addr;
    logic                        desc_valid;
    logic [31:0][7:0]            ep_stat;
  } state_type;

  state_type q;
  state_type d;

  // True when an address falls inside the endpoint status window.
  function automatic logic in_ep_window(input logic [11:0] a);
    in_ep_window = (a >= usb_irq_pkg::OFF_EP_BASE) && (a <= usb_irq_pkg::OFF_EP_LAST);
  endfunction

  // Index into the endpoint status array: endpoint times two, IN in bit 0.
  function automatic logic [4:0] ep_index(input logic [11:0] a);
    ep_index = a[6:2];
  endfunction

  // Register read decode shared by the read path and the write response.
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && ((a <= usb_irq_pkg::OFF_LINK_STAT) || in_ep_window(a));
  endfunction

  logic       wr_fire;
  logic       rd_fire;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic [7:0] hw_set_a;
  logic [7:0] hw_set_b;
  logic       level_on;
  logic       irq_pending;
  logic       ev_in;
  logic [4:0] ev_idx;

  assign s_axi_awready_out = !q.aw_held && !q.bvalid;
  assign s_axi_wready_out  = !q.w_held && !q.bvalid;
  assign s_axi_arready_out = !q.rvalid;
  assign wr_fire = q.aw_held && q.w_held && !q.bvalid;
  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign wr_byte = q.wstrb0 ? q.wdata : 8'h00;
  assign ev_in   = ep_event_in.valid;
  assign ev_idx  = {ep_event_in.ep_num, ep_event_in.dir_in};

  // Hardware event sources; they are merged after software clears so that set wins.
  always_comb
  begin
    hw_set_a = 8'h00;
    hw_set_b = 8'h00;
    hw_set_a[usb_irq_pkg::FA_SOF]   = sof_rx_in;
    hw_set_a[usb_irq_pkg::FA_IDLE]  = (q.link == usb_irq_pkg::LINK_ACTIVE) && bus_idle_in
                                      && !bus_reset_in
                                      && (q.idle_cnt == 16'(IDLE_LIMIT - 1));
    hw_set_a[usb_irq_pkg::FA_WAKE]  = bus_wake_out;
    hw_set_a[usb_irq_pkg::FA_RESET] = bus_reset_in;
    hw_set_a[usb_irq_pkg::FA_CRC]   = ev_in && ep_event_in.crc_err
                                      && ep_event_in.iso;
    hw_set_a[usb_irq_pkg::FA_STARV] = ev_in && ep_event_in.starved
                                      && ep_event_in.dir_in;
    hw_set_a[usb_irq_pkg::FA_REFUS] = ev_in && ep_event_in.starved
                                      && !ep_event_in.dir_in;
    hw_set_a[usb_irq_pkg::FA_STALL] = ev_in && ep_event_in.stall;
    hw_set_b[usb_irq_pkg::FB_XFER]  = fifo_pending_in;
    hw_set_b[usb_irq_pkg::FB_SETUP] = ev_in && ep_event_in.setup_ok;
  end

  // Read data mux; both flag addresses return the same byte.
  always_comb
  begin
    rd_byte = 8'h00;
    case (s_axi_araddr_in)
      usb_irq_pkg::OFF_PTR_LOW:   rd_byte = q.ptr_low;
      usb_irq_pkg::OFF_PTR_HIGH:  rd_byte = q.ptr_high;
      usb_irq_pkg::OFF_CTRL_A:    rd_byte = q.ctrl_a;
      usb_irq_pkg::OFF_CTRL_B:    rd_byte = q.ctrl_b;
      usb_irq_pkg::OFF_FLAGA_CLR: rd_byte = q.flags_a;
      usb_irq_pkg::OFF_FLAGA_SET: rd_byte = q.flags_a;
      usb_irq_pkg::OFF_FLAGB_CLR: rd_byte = q.flags_b;
      usb_irq_pkg::OFF_FLAGB_SET: rd_byte = q.flags_b;
      usb_irq_pkg::OFF_TRIM_LOW:  rd_byte = q.trim_low;
      usb_irq_pkg::OFF_TRIM_HIGH: rd_byte = q.trim_high;
      usb_irq_pkg::OFF_LINK_STAT: rd_byte = {7'h00, q.link == usb_irq_pkg::LINK_SUSPENDED};
      default:
      begin
        if (in_ep_window(s_axi_araddr_in) && (s_axi_araddr_in[1:0] == 2'h0))
        begin
          rd_byte = q.ep_stat[ep_index(s_axi_araddr_in)];
        end
      end
    endcase
  end

  always_comb
  begin
    d = q;
    // Write address and data are taken in either order and held until both are present.
    if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      d.aw_held = 1'b1;
      d.awaddr  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      d.w_held = 1'b1;
      d.wdata  = s_axi_wdata_in[7:0];
      d.wstrb0 = s_axi_wstrb_in[0];
    end
    if (q.bvalid && s_axi_bready_in)
    begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready_in)
    begin
      d.rvalid = 1'b0;
    end
    if (rd_fire)
    begin
      d.rvalid = 1'b1;
      d.rdata  = rd_byte;
      d.rresp  = mapped(s_axi_araddr_in) ? usb_irq_pkg::RESP_OKAY : usb_irq_pkg::RESP_SLVERR;
    end

    // Software writes; flag clears come first so hardware sets below override them.
    if (wr_fire)
    begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = mapped(q.awaddr) ? usb_irq_pkg::RESP_OKAY : usb_irq_pkg::RESP_SLVERR;
      case (q.awaddr)
        usb_irq_pkg::OFF_PTR_LOW:   d.ptr_low   = wr_byte & usb_irq_pkg::MASK_PTR_LOW;
        usb_irq_pkg::OFF_PTR_HIGH:  d.ptr_high  = wr_byte;
        usb_irq_pkg::OFF_CTRL_A:    d.ctrl_a    = wr_byte & usb_irq_pkg::MASK_CTRL_A;
        usb_irq_pkg::OFF_CTRL_B:    d.ctrl_b    = wr_byte & usb_irq_pkg::MASK_CTRL_B;
        usb_irq_pkg::OFF_FLAGA_CLR: d.flags_a   = q.flags_a & ~wr_byte;
        usb_irq_pkg::OFF_FLAGA_SET: d.flags_a   = q.flags_a | wr_byte;
        usb_irq_pkg::OFF_FLAGB_CLR: d.flags_b   = q.flags_b & ~(wr_byte & 8'h03);
        usb_irq_pkg::OFF_FLAGB_SET: d.flags_b   = q.flags_b | (wr_byte & 8'h03);
        usb_irq_pkg::OFF_TRIM_LOW:  d.trim_low  = wr_byte;
        usb_irq_pkg::OFF_TRIM_HIGH: d.trim_high = wr_byte;
        default:
        begin
          // Endpoint status bits 7 to 4 clear by writing one.
          if (in_ep_window(q.awaddr) && (q.awaddr[1:0] == 2'h0))
          begin
            d.ep_stat[ep_index(q.awaddr)] = q.ep_stat[ep_index(q.awaddr)] & ~wr_byte;
          end
        end
      endcase
    end
    d.flags_a = d.flags_a | hw_set_a;
    d.flags_b = d.flags_b | hw_set_b;

    // Suspend timing: the idle counter only runs while the line stays idle.
    case (q.link)
      usb_irq_pkg::LINK_ACTIVE:
      begin
        if (!bus_idle_in || bus_reset_in)
        begin
          d.idle_cnt = 16'h0000;
        end
        else if (hw_set_a[usb_irq_pkg::FA_IDLE])
        begin
          d.idle_cnt = 16'h0000;
          d.link     = usb_irq_pkg::LINK_SUSPENDED;
        end
        else
        begin
          d.idle_cnt = q.idle_cnt + 16'h0001;
        end
      end
      usb_irq_pkg::LINK_SUSPENDED:
      begin
        if (!bus_idle_in || bus_reset_in)
        begin
          d.link = usb_irq_pkg::LINK_ACTIVE;
        end
      end
      default:
      begin
        d.link     = usb_irq_pkg::LINK_ACTIVE;
        d.idle_cnt = 16'h0000;
      end
    endcase

    // Endpoint event: locate the descriptor and mark its status byte.
    d.desc_valid = ev_in;
    if (ev_in)
    begin
      d.desc_addr = {q.ptr_high, q.ptr_low}
                    + {8'h00, ep_event_in.ep_num, 4'h0}
                    + (ep_event_in.dir_in ? 16'(usb_irq_pkg::EP_IN_OFFSET)
                                          : 16'h0000);
      if (ep_event_in.stall || (ep_event_in.crc_err && ep_event_in.iso && !ep_event_in.dir_in))
      begin
        d.ep_stat[ev_idx][usb_irq_pkg::EP_STALL_CRC] = 1'b1;
      end
      if (ep_event_in.starved)
      begin
        d.ep_stat[ev_idx][usb_irq_pkg::EP_STARVE] = 1'b1;
      end
      if (ep_event_in.xfer_ok)
      begin
        d.ep_stat[ev_idx][usb_irq_pkg::EP_XFER_DONE] = 1'b1;
        d.ep_stat[ev_idx][usb_irq_pkg::EP_XFER_ALT]  = 1'b1;
      end
      if (ep_event_in.setup_ok)
      begin
        d.ep_stat[ev_idx][usb_irq_pkg::EP_XFER_ALT] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      q           <= '0;
      q.ctrl_a    <= usb_irq_pkg::RST_BYTE;
      q.ctrl_b    <= usb_irq_pkg::RST_BYTE;
      q.ptr_low   <= usb_irq_pkg::RST_BYTE;
      q.ptr_high  <= usb_irq_pkg::RST_BYTE;
      q.link      <= usb_irq_pkg::LINK_ACTIVE;
    end
    else
    begin
      q <= d;
    end
  end

  // Interrupt request; a zero level silences every source.
  assign level_on    = (q.ctrl_a[1:0] != 2'h0);
  assign irq_pending =
      (q.flags_a[usb_irq_pkg::FA_SOF] && q.ctrl_a[usb_irq_pkg::BIT_SOF_EN])
    || ((|q.flags_a[6:4]) && q.ctrl_a[usb_irq_pkg::BIT_BUSEV_EN])
    || ((|q.flags_a[3:1]) && q.ctrl_a[usb_irq_pkg::BIT_FAULT_EN])
    || (q.flags_a[usb_irq_pkg::FA_STALL] && q.ctrl_a[usb_irq_pkg::BIT_STALL_EN])
    || (q.flags_b[usb_irq_pkg::FB_XFER] && q.ctrl_b[usb_irq_pkg::BIT_XFER_EN])
    || (q.flags_b[usb_irq_pkg::FB_SETUP] && q.ctrl_b[usb_irq_pkg::BIT_SETUP_EN]);
  // The wake term is combinational so a halted clock still lets it reach the CPU.
  assign bus_wake_out  = (q.link == usb_irq_pkg::LINK_SUSPENDED) && !bus_idle_in;
  assign irq_out       = level_on && (irq_pending
                         || (bus_wake_out && q.ctrl_a[usb_irq_pkg::BIT_BUSEV_EN]));
  assign irq_level_out = q.ctrl_a[1:0];

  assign s_axi_bvalid_out = q.bvalid;
  assign s_axi_bresp_out  = q.bresp;
  assign s_axi_rvalid_out = q.rvalid;
  assign s_axi_rdata_out  = {24'h000000, q.rdata};
  assign s_axi_rresp_out  = q.rresp;
  assign desc_addr_out    = q.desc_addr;
  assign desc_valid_out   = q.desc_valid;
  assign pad_trim_out     = {q.trim_high, q.trim_low};

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_ep_stall;
    ev_in && ep_event_in.stall;
  endsequence

  sequence s_read_flag_a;
    rd_fire && ((s_axi_araddr_in == usb_irq_pkg::OFF_FLAGA_CLR)
             || (s_axi_araddr_in == usb_irq_pkg::OFF_FLAGA_SET));
  endsequence

  sequence s_idle_expire;
    (q.link == usb_irq_pkg::LINK_ACTIVE) && bus_idle_in && !bus_reset_in
      && (q.idle_cnt == 16'(IDLE_LIMIT - 1));
  endsequence

  a_sof_flag_set: assert property (sof_rx_in |=> q.flags_a[7])
    else $error("frame-start flag not set");
  a_idle_flag_time: assert property (s_idle_expire |=> q.flags_a[6]
      && (q.link == usb_irq_pkg::LINK_SUSPENDED))
    else $error("idle flag not set on timeout");
  a_wake_async_out: assert property ((q.link == usb_irq_pkg::LINK_SUSPENDED) && !bus_idle_in
      |-> bus_wake_out ##1 q.flags_a[5])
    else $error("wake not raised during suspend");
  a_reset_flag_set: assert property (bus_reset_in |=> q.flags_a[4])
    else $error("bus reset flag not set");
  a_irq_level_gate: assert property ((q.ctrl_a[1:0] == 2'h0) |-> !irq_out)
    else $error("interrupt with zero level");
  a_irq_sof_enable: assert property (q.flags_a[7] && q.ctrl_a[7] && (q.ctrl_a[1:0] != 2'h0)
      |-> irq_out)
    else $error("enabled frame-start flag gave no interrupt");
  a_flag_read_same: assert property (s_read_flag_a |=> s_axi_rvalid_out
      && (s_axi_rdata_out[7:0] == $past(q.flags_a)))
    else $error("flag read mismatch");
  a_desc_addr_calc: assert property (ev_in |=> desc_valid_out && (desc_addr_out ==
      $past({q.ptr_high, q.ptr_low}) + {8'h00, $past(ep_event_in.ep_num), 4'h0}
      + ($past(ep_event_in.dir_in) ? 16'h0008 : 16'h0000)))
    else $error("descriptor address wrong");
  a_ep_stall_mark: assert property (s_ep_stall |=> q.ep_stat[$past({ep_event_in.ep_num,
      ep_event_in.dir_in})][7] && q.flags_a[0])
    else $error("stall not recorded");
  a_wr_resp_once: assert property (wr_fire |=> s_axi_bvalid_out && !s_axi_awready_out)
    else $error("write response missing");

endmodule

// [bench/usb_host_model.sv]
// Purpose: Host side stand-in driving frame, reset, bus state and endpoint events.
// Assumes: Strobes are launched by non-blocking assignment just after a rising edge.
// Notes:   Strobes last one cycle; bus idle and completion pending are levels.
`timescale 1ns/1ps
module usb_host_model
(
  // Clock
  input  wire logic                      clk_in,
  // Bus events toward the device
  output      logic                      sof_out,
  output      logic                      idle_out,
  output      logic                      reset_out,
  output      logic                      pending_out,
  output      usb_irq_pkg::ep_event_type ev_out
);
  initial
  begin
    sof_out     = 1'b0;
    idle_out    = 1'b0;
    reset_out   = 1'b0;
    pending_out = 1'b0;
    ev_out      = '0;
  end

  // A strobe left high would be seen as a second event, so it drops one edge later.
  task automatic strobe(input logic s, input logic r, input usb_irq_pkg::ep_event_type e);
    @(posedge clk_in);
    sof_out   <= s;
    reset_out <= r;
    ev_out    <= e;
    @(posedge clk_in);
    sof_out   <= 1'b0;
    reset_out <= 1'b0;
    ev_out    <= '0;
  endtask

  task automatic level(input logic idle, input logic pend);
    @(posedge clk_in);
    idle_out    <= idle;
    pending_out <= pend;
  endtask
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench for the USB interrupt and endpoint status block.
// Assumes: 10 MHz clock, short idle limit, ready signals always high on the master side.
// Notes:   Bus results are queued by the drivers and compared by a negedge monitor.
`timescale 1ns/1ps
module testbench;
  localparam int IDLE = 20;
  logic                      clk, rst, awv, wv, arv;
  logic [11:0]               awa, ara, a;
  logic [31:0]               wd;
  logic [7:0]                r, m, ena, enb;
  logic [15:0]               base;
  usb_irq_pkg::ep_event_type e, ev;
  logic                      sof, idle, bres, pend;
  wire logic                 awr, wrr, bv, arr, rv, dv, irq, wake;
  wire logic [1:0]           br, rr, lvl;
  wire logic [31:0]          rdat;
  wire logic [15:0]          da, trim;
  int                        err_count, cmp_count;
  logic [33:0]               rq[$];
  logic [1:0]                bq[$];
  logic [7:0]                ea[6] = '{8'h01, 8'h08, 8'h04, 8'h02, 8'h00, 8'h00};
  logic [7:0]                ee[6] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h30, 8'h10};
  logic [5:0]                din = 6'b010101;

  usb_irq_status #(.IDLE_LIMIT(IDLE)) DUT (
    .sys_clk_in(clk), .rst_in(rst), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(1'b1), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(1'b1), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr),
    .sof_rx_in(sof), .bus_idle_in(idle), .bus_reset_in(bres), .fifo_pending_in(pend),
    .ep_event_in(ev), .desc_addr_out(da), .desc_valid_out(dv), .pad_trim_out(trim),
    .irq_out(irq), .irq_level_out(lvl), .bus_wake_out(wake));

  usb_host_model host (.clk_in(clk), .sof_out(sof), .idle_out(idle), .reset_out(bres),
    .pending_out(pend), .ev_out(ev));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    @(negedge clk);
    cmp({18'h0, got}, {18'h0, exp});
  endtask

  // Ready is sampled at the negedge, where it has settled, and acted on at the next edge.
  task automatic wr(input logic [11:0] ad, input logic [7:0] d, input logic [1:0] rs = 2'h0);
    logic pa, pw;
    bq.push_back(rs);
    @(posedge clk);
    awv <= 1'b1;
    wv  <= 1'b1;
    awa <= ad;
    wd  <= {24'h0, d};
    do
    begin
      @(negedge clk);
      pa = awv && !awr;
      pw = wv && !wrr;
      @(posedge clk);
      awv <= pa;
      wv  <= pw;
    end
    while (pa || pw);
    do @(negedge clk); while (!bv);
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] ad, input logic [7:0] d, input logic [1:0] rs = 2'h0);
    logic p;
    rq.push_back({rs, 24'h0, d});
    @(posedge clk);
    arv <= 1'b1;
    ara <= ad;
    do
    begin
      @(negedge clk);
      p = !arr;
      @(posedge clk);
      arv <= p;
    end
    while (p);
    do @(negedge clk); while (!rv);
    @(posedge clk);
  endtask

  always @(negedge clk)
  begin
    if (bv)
      cmp({br, 32'h0}, {bq.pop_front(), 32'h0});
    if (rv)
      cmp({rr, rdat}, rq.pop_front());
  end

  task automatic conclude();
    $display("compared %0d, mismatched %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial
  begin
    {rst, awv, wv, arv, awa, ara, wd} = {1'b1, 3'b0, 12'h0, 12'h0, 32'h0};
    void'($urandom(18623));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++)
      rd(12'(4 * i), 8'h00);
    rd(12'h030, 8'h00, usb_irq_pkg::RESP_SLVERR);
    wr(12'h00A, 8'hFF, usb_irq_pkg::RESP_SLVERR);
    $display("test reset done");
    r = 8'($urandom);
    m = 8'($urandom);
    base = {r, m & 8'hFE};
    wr(usb_irq_pkg::OFF_PTR_HIGH, r);
    wr(usb_irq_pkg::OFF_PTR_LOW, m);
    rd(usb_irq_pkg::OFF_PTR_HIGH, r);
    rd(usb_irq_pkg::OFF_PTR_LOW, m & 8'hFE);
    wr(usb_irq_pkg::OFF_TRIM_LOW, m);
    wr(usb_irq_pkg::OFF_TRIM_HIGH, r);
    chk(trim, {r, m});
    wr(usb_irq_pkg::OFF_CTRL_A, 8'hFF);
    wr(usb_irq_pkg::OFF_CTRL_B, 8'hFF);
    rd(usb_irq_pkg::OFF_CTRL_A, 8'hF3);
    rd(usb_irq_pkg::OFF_CTRL_B, 8'h03);
    wr(usb_irq_pkg::OFF_FLAGA_SET, r);
    wr(usb_irq_pkg::OFF_FLAGA_SET, 8'h00);
    rd(usb_irq_pkg::OFF_FLAGA_CLR, r);
    wr(usb_irq_pkg::OFF_FLAGA_CLR, m);
    rd(usb_irq_pkg::OFF_FLAGA_SET, r & ~m);
    wr(usb_irq_pkg::OFF_FLAGA_CLR, 8'hFF);
    $display("test registers done");
    for (int b = 0; b < 10; b++)
    begin
      ena = (b > 7) ? 8'h00 : (b == 7) ? 8'h80 : (b > 3) ? 8'h40 : (b > 0) ? 8'h20 : 8'h10;
      enb = (b > 7) ? 8'(b - 7) : 8'h00;
      m = 8'($urandom_range(3, 1));
      wr(usb_irq_pkg::OFF_CTRL_A, ena | m);
      wr(usb_irq_pkg::OFF_CTRL_B, enb);
      wr(b > 7 ? usb_irq_pkg::OFF_FLAGB_SET : usb_irq_pkg::OFF_FLAGA_SET, 8'(1 << (b % 8)));
      chk({15'h0, irq}, 16'h1);
      chk({14'h0, lvl}, {14'h0, m[1:0]});
      wr(usb_irq_pkg::OFF_CTRL_A, ena);
      chk({15'h0, irq}, 16'h0);
      wr(usb_irq_pkg::OFF_CTRL_A, ~ena & 8'hF0 | m);
      wr(usb_irq_pkg::OFF_CTRL_B, ~enb & 8'h03);
      chk({15'h0, irq}, 16'h0);
      wr(usb_irq_pkg::OFF_FLAGA_CLR, 8'hFF);
      wr(usb_irq_pkg::OFF_FLAGB_CLR, 8'h03);
      chk({15'h0, irq}, 16'h0);
    end
    $display("test interrupts done");
    host.strobe(1'b1, 1'b0, '0);
    rd(usb_irq_pkg::OFF_FLAGA_SET, 8'h80);
    host.strobe(1'b0, 1'b1, '0);
    rd(usb_irq_pkg::OFF_FLAGA_CLR, 8'h90);
    wr(usb_irq_pkg::OFF_FLAGA_CLR, 8'hFF);
    for (int i = 0; i < 6; i++)
    begin
      e = '0;
      e.valid = 1'b1;
      e.ep_num = 4'($urandom);
      e.dir_in = din[i];
      e.iso = (i == 1);
      e.stall = (i == 0);
      e.crc_err = (i == 1);
      e.starved = (i == 2) || (i == 3);
      e.xfer_ok = (i == 4);
      e.setup_ok = (i == 5);
      host.strobe(1'b0, 1'b0, e);
      @(negedge clk);
      cmp({33'h0, dv}, 34'h1);
      cmp({18'h0, da}, {18'h0, base + 16'({e.ep_num, e.dir_in, 3'b000})});
      rd(usb_irq_pkg::OFF_FLAGA_SET, ea[i]);
      rd(usb_irq_pkg::OFF_FLAGB_SET, (i == 5) ? 8'h01 : 8'h00);
      a = usb_irq_pkg::OFF_EP_BASE + 12'({e.ep_num, e.dir_in, 2'b00});
      rd(a, ee[i]);
      wr(a, 8'hFF);
      rd(a, 8'h00);
      wr(usb_irq_pkg::OFF_FLAGA_CLR, 8'hFF);
      wr(usb_irq_pkg::OFF_FLAGB_CLR, 8'h03);
    end
    host.level(1'b0, 1'b1);
    wr(usb_irq_pkg::OFF_FLAGB_CLR, 8'h02);
    rd(usb_irq_pkg::OFF_FLAGB_SET, 8'h02);
    host.level(1'b0, 1'b0);
    wr(usb_irq_pkg::OFF_FLAGB_CLR, 8'h02);
    rd(usb_irq_pkg::OFF_FLAGB_SET, 8'h00);
    $display("test events done");
    wr(usb_irq_pkg::OFF_CTRL_A, 8'h41);
    host.level(1'b1, 1'b0);
    repeat (IDLE - 12) @(posedge clk);
    rd(usb_irq_pkg::OFF_FLAGA_SET, 8'h00);
    repeat (IDLE) @(posedge clk);
    rd(usb_irq_pkg::OFF_FLAGA_SET, 8'h40);
    rd(usb_irq_pkg::OFF_LINK_STAT, 8'h01);
    wr(usb_irq_pkg::OFF_FLAGA_CLR, 8'hFF);
    host.level(1'b0, 1'b0);
    @(negedge clk);
    cmp({32'h0, wake, irq}, 34'h3);
    rd(usb_irq_pkg::OFF_FLAGA_SET, 8'h20);
    rd(usb_irq_pkg::OFF_LINK_STAT, 8'h00);
    $display("test suspend done");
    conclude();
  end
endmodule
